// file: shared/asp_pkg.sv
package asp_pkg;
  // register byte addresses
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_IER = 8'h04;
  localparam logic [7:0] A_IIR = 8'h08;
  localparam logic [7:0] A_LCR = 8'h0c;
  localparam logic [7:0] A_DCR = 8'h10;
  localparam logic [7:0] A_LSR = 8'h14;
  localparam logic [7:0] A_BDR = 8'h20;
  localparam logic [7:0] A_BFR = 8'h24;
  localparam logic [7:0] A_INTERFRAME_DELAY = 8'h30;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_BDR = 16'h0000;
  localparam logic [7:0] IIR_NONE = 8'h01;
  // line_control fields
  localparam int LCR_BRK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_PSEL = 4;
  localparam int LCR_PEN = 3;
  localparam int LCR_STOP = 2;
  // line_inversion_control fields
  localparam int DCR_RECEIVE_LINE_INVERT = 3;
  localparam int DCR_TRANSMIT_LINE_INVERT = 2;
  // line_status fields
  localparam int LSR_SHIFTER_IDLE_FLAG = 6;
  localparam int LSR_HOLDING_EMPTY_FLAG = 5;
  localparam int LSR_BI = 4;
  localparam int LSR_FE = 3;
  localparam int LSR_PE = 2;
  localparam int LSR_OE = 1;
  localparam int LSR_DR = 0;
  // interrupt_enables fields
  localparam int IE_DTX = 5;
  localparam int IE_DRX = 4;
  localparam int IE_TXE = 3;
  localparam int IE_RLS = 2;
  localparam int IE_HOLDING_EMPTY_FLAG = 1;
  localparam int IE_RDA = 0;
  // interrupt_identification codes
  localparam logic [7:0] IIR_RLS = 8'h06;
  localparam logic [7:0] IIR_RDA = 8'h04;
  localparam logic [7:0] IIR_HOLDING_EMPTY_FLAG = 8'h02;
  localparam logic [7:0] IIR_TXE = 8'h10;
  localparam logic [7:0] IIR_DRX = 8'h0c;
  localparam logic [7:0] IIR_DTX = 8'h0a;
  // timing in 16x sample ticks
  localparam logic [7:0] BIT_TICKS = 8'h10;
  localparam logic [7:0] STOP15_TICKS = 8'h18;
  localparam logic [7:0] STOP2_TICKS = 8'h20;
  localparam logic [7:0] GAP_UNIT = 8'h20;
  localparam logic [3:0] SAMPLE_AT = 4'h6;
  localparam logic [3:0] BIT_END = 4'hf;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100,
    TX_GAP = 3'b101
  } asp_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } asp_rx_t;
endpackage

// file: logic/asp_baud.sv
`timescale 1ns/100ps
module asp_baud (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] divisor,
  input wire logic [7:0] fraction,
  output wire logic tick
);
  logic [16:0] cnt;
  logic [7:0] acc;
  logic stretch;
  wire [16:0] period = {1'b0, divisor} + {16'h0000, stretch};
  wire [8:0] next_acc = {1'b0, acc} + {1'b0, fraction};

  // zero divisor parks the generator; >= survives a shrinking divisor
  assign tick = (divisor != 16'h0000) && (cnt >= period - 17'h00001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 17'h00000;
      acc <= 8'h00;
      stretch <= 1'b0;
    end else if (tick) begin
      cnt <= 17'h00000;
      acc <= next_acc[7:0];
      stretch <= next_acc[8];
    end else begin
      cnt <= cnt + 17'h00001;
    end
  end

  AST_TICK_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    tick && divisor > 16'h0001 |=> !tick || divisor != $past(divisor))
    else $error("sample tick repeated too soon");
endmodule // asp_baud

// file: logic/asp_channel.sv
// Implementation choice: register access over APB.
`timescale 1ns/100ps
// Operation
// - prescaler divides pclk by a 16-bit divisor from 1 to 65535.
// - bit rate is prescaled clock over 16, with 8-bit fraction tuning.
// - length field 00..11 selects five to eight data bits.
// - stop select gives 1.5 stops for five bits, else two stops.
// - parity off, odd, even, or forced one/zero by sticky select.
// - break bit holds the transmit line low.
// - inversion bits invert the receive input and transmit output.
// - receive buffer holds last character until a newer one arrives.
// - holding register is write-only and moves to an empty shifter.
// - enable register holds six enables in bits 5 down to 0.
// - identification bit 0 reads 0 when pending, reset value 0x01.
// - id codes 011, 010, 001, 110, 101 in that priority.
// - each pending source clears on its documented read or write.
// - bit 4 flags shifter empty, alone; transmit DMA done has its own code 101.
// - status bits 6 and 5 show shifter idle and holding empty.
// - framing error bit 3 and parity error bit 2 are set.
// - overrun bit 1 sets when a character lands on unread data.
// - break bit 4 on break, data ready bit 0 on storing.
// - status bits 1 to 4 raise line status interrupt when enabled.
// - falling edge starts a frame; 16 samples per bit, 7th decides.
// - start, data LSB first, optional parity, then stop bits.
// - fraction accumulator overflow stretches one period by one clock.
// - gap value of 2 or more holds the line high after each character.
module asp_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  input wire logic dma_rx_done,
  input wire logic dma_tx_done,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output wire logic irq
);
  // parity of a character masked to its length
  function automatic logic asp_par(input logic [7:0] d,
                                   input logic [6:0] l);
    logic [7:0] m;
    m = d & (8'hff >> (~l[1:0]));
    if (l[asp_pkg::LCR_STICK]) begin
      return ~l[asp_pkg::LCR_PSEL];
    end
    return (^m) ^ ~l[asp_pkg::LCR_PSEL];
  endfunction

  logic [5:0] interrupt_enables;
  logic [6:0] line_control;
  logic [1:0] line_inversion_control;
  logic [15:0] baud_divisor;
  logic [7:0] baud_fraction;
  logic [2:0] interframe_delay;
  logic [7:0] receive_buffer;
  logic [7:0] transmit_holding;
  logic thr_full;
  logic dr, oe, pe, fe, bi;
  logic rda_p, holding_empty_flag_p, txe_p, drx_p, dtx_p;
  asp_pkg::asp_tx_t tx_st;
  logic [7:0] tx_tk;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par;
  asp_pkg::asp_rx_t rx_st;
  logic [3:0] rx_tk;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_zero, rx_perr;
  logic s1, s2, s3, rx_f, rx_prev;
  wire tick;

  asp_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(baud_divisor),
    .fraction(baud_fraction),
    .tick(tick)
  );

  // bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_data = paddr == asp_pkg::A_DATA;
  wire hit_ier = paddr == asp_pkg::A_IER;
  wire hit_iir = paddr == asp_pkg::A_IIR;
  wire hit_lcr = paddr == asp_pkg::A_LCR;
  wire hit_dcr = paddr == asp_pkg::A_DCR;
  wire hit_lsr = paddr == asp_pkg::A_LSR;
  wire hit_bdr = paddr == asp_pkg::A_BDR;
  wire hit_bfr = paddr == asp_pkg::A_BFR;
  wire hit_interframe_delay = paddr == asp_pkg::A_INTERFRAME_DELAY;
  wire mapped = hit_data | hit_ier | hit_iir | hit_lcr | hit_dcr |
                hit_lsr | hit_bdr | hit_bfr | hit_interframe_delay;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  wire wr_thr = wr & hit_data;
  wire rd_rbr = rd & hit_data;
  wire rd_lsr = rd & hit_lsr;
  wire rd_iir = rd & hit_iir;

  // status and interrupt view
  wire shifter_idle_flag = tx_st == asp_pkg::TX_IDLE;
  wire [7:0] line_status = {1'b0, shifter_idle_flag, ~thr_full, bi, fe, pe, oe, dr};
  wire rls = oe | pe | fe | bi;
  wire [5:0] act = {dtx_p, drx_p, txe_p, rls, holding_empty_flag_p, rda_p} & interrupt_enables;
  wire [7:0] interrupt_identification = act[asp_pkg::IE_RLS] ? asp_pkg::IIR_RLS :
                   act[asp_pkg::IE_RDA] ? asp_pkg::IIR_RDA :
                   act[asp_pkg::IE_HOLDING_EMPTY_FLAG] ? asp_pkg::IIR_HOLDING_EMPTY_FLAG :
                   act[asp_pkg::IE_TXE] ? asp_pkg::IIR_TXE :
                   act[asp_pkg::IE_DRX] ? asp_pkg::IIR_DRX :
                   act[asp_pkg::IE_DTX] ? asp_pkg::IIR_DTX :
                   asp_pkg::IIR_NONE;
  assign irq = ~interrupt_identification[0];

  // the transmit holding register reads back as the receive buffer
  wire [7:0] rd_byte = hit_data ? receive_buffer :
                       hit_ier ? {2'b00, interrupt_enables} :
                       hit_iir ? interrupt_identification :
                       hit_lcr ? {1'b0, line_control} :
                       hit_dcr ? {4'h0, line_inversion_control, 2'b00} :
                       hit_lsr ? line_status :
                       hit_bfr ? baud_fraction :
                       hit_interframe_delay ? {5'h00, interframe_delay} : 8'h00;
  wire [31:0] next_rdata = hit_bdr ? {16'h0000, baud_divisor} : {24'h000000, rd_byte};

  // status and id reads clear only what the captured read showed, so a flag set
  // between setup and access is never lost
  wire clr_oe = rd_lsr & prdata[asp_pkg::LSR_OE];
  wire clr_pe = rd_lsr & prdata[asp_pkg::LSR_PE];
  wire clr_fe = rd_lsr & prdata[asp_pkg::LSR_FE];
  wire clr_bi = rd_lsr & prdata[asp_pkg::LSR_BI];
  wire clr_rda = rd_rbr | (rd_iir & prdata[7:0] == asp_pkg::IIR_RDA);
  wire clr_holding_empty_flag = wr_thr | (rd_iir & prdata[7:0] == asp_pkg::IIR_HOLDING_EMPTY_FLAG);
  wire clr_txe = wr_thr | (rd_iir & prdata[7:0] == asp_pkg::IIR_TXE);
  wire clr_drx = rd_iir & prdata[7:0] == asp_pkg::IIR_DRX;
  wire clr_dtx = rd_iir & prdata[7:0] == asp_pkg::IIR_DTX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= next_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enables <= 6'h00;
      line_control <= 7'h00;
      line_inversion_control <= 2'b00;
      baud_divisor <= asp_pkg::RST_BDR;
      baud_fraction <= asp_pkg::RST_BYTE;
      interframe_delay <= 3'h0;
    end else if (wr) begin
      if (hit_ier) interrupt_enables <= pwdata[5:0];
      if (hit_lcr) line_control <= pwdata[6:0];
      if (hit_dcr) line_inversion_control <= pwdata[3:2];
      if (hit_bdr) baud_divisor <= pwdata[15:0];
      if (hit_bfr) baud_fraction <= pwdata[7:0];
      if (hit_interframe_delay) interframe_delay <= pwdata[2:0];
    end
  end

  // transmitter
  wire [2:0] last_bit = 3'h4 + {1'b0, line_control[1:0]};
  wire [7:0] stop_len = !line_control[asp_pkg::LCR_STOP] ? asp_pkg::BIT_TICKS :
                        line_control[1:0] == 2'b00 ? asp_pkg::STOP15_TICKS :
                        asp_pkg::STOP2_TICKS;
  wire [7:0] gap_len = {6'h00, interframe_delay[2:1]} * asp_pkg::GAP_UNIT;
  wire [7:0] tx_len = tx_st == asp_pkg::TX_STOP ? stop_len :
                      tx_st == asp_pkg::TX_GAP ? gap_len :
                      asp_pkg::BIT_TICKS;
  wire tx_end = tick && tx_tk == tx_len - 8'h01;
  wire tx_load = shifter_idle_flag & thr_full;
  wire tx_done = tx_end & ((tx_st == asp_pkg::TX_STOP & gap_len == 8'h00)
                           | tx_st == asp_pkg::TX_GAP);
  wire tx_line = tx_st == asp_pkg::TX_START ? 1'b0 :
                 tx_st == asp_pkg::TX_DATA ? tx_sh[0] :
                 tx_st == asp_pkg::TX_PAR ? tx_par : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_holding <= asp_pkg::RST_BYTE;
      thr_full <= 1'b0;
    end else begin
      if (wr_thr) transmit_holding <= pwdata[7:0];
      // a write in the load cycle refills the register at once
      thr_full <= wr_thr | (thr_full & ~tx_load);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_tk <= 8'h00;
    end else if (shifter_idle_flag | tx_end) begin
      tx_tk <= 8'h00;
    end else if (tick) begin
      tx_tk <= tx_tk + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= asp_pkg::TX_IDLE;
      tx_bit <= 3'h0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
    end else begin
      unique case (tx_st)
        asp_pkg::TX_IDLE: if (tx_load) begin
          tx_st <= asp_pkg::TX_START;
          tx_sh <= transmit_holding;
          tx_par <= asp_par(transmit_holding, line_control);
          tx_bit <= 3'h0;
        end
        asp_pkg::TX_START: if (tx_end) tx_st <= asp_pkg::TX_DATA;
        asp_pkg::TX_DATA: if (tx_end) begin
          tx_sh <= {1'b0, tx_sh[7:1]};
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == last_bit) begin
            tx_st <= line_control[asp_pkg::LCR_PEN] ? asp_pkg::TX_PAR :
                     asp_pkg::TX_STOP;
          end
        end
        asp_pkg::TX_PAR: if (tx_end) tx_st <= asp_pkg::TX_STOP;
        asp_pkg::TX_STOP: if (tx_end) begin
          tx_st <= gap_len == 8'h00 ? asp_pkg::TX_IDLE :
                   asp_pkg::TX_GAP;
        end
        asp_pkg::TX_GAP: if (tx_end) tx_st <= asp_pkg::TX_IDLE;
        default: tx_st <= asp_pkg::TX_IDLE;
      endcase
    end
  end

  // break wins over inversion so the pin really sits low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_line <= 1'b1;
    end else begin
      serial_out_line <= line_control[asp_pkg::LCR_BRK] ? 1'b0 :
                         tx_line ^ line_inversion_control[asp_pkg::DCR_TRANSMIT_LINE_INVERT - 2];
    end
  end

  // receiver input: three flops, a change counts when two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      rx_f <= 1'b1;
    end else begin
      s1 <= serial_in_line;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) rx_f <= s3;
    end
  end

  wire rxi = rx_f ^ line_inversion_control[asp_pkg::DCR_RECEIVE_LINE_INVERT - 2];
  wire rx_fall = rx_prev & ~rxi;
  wire samp = tick && rx_tk == asp_pkg::SAMPLE_AT;
  wire bend = tick && rx_tk == asp_pkg::BIT_END;
  wire [7:0] rx_data = rx_sh >> (~line_control[1:0]);
  wire rx_done = samp & rx_st == asp_pkg::RX_STOP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev <= 1'b1;
      rx_tk <= 4'h0;
    end else begin
      rx_prev <= rxi;
      if (rx_st == asp_pkg::RX_IDLE) rx_tk <= 4'h0;
      else if (tick) rx_tk <= rx_tk + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= asp_pkg::RX_IDLE;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_zero <= 1'b1;
      rx_perr <= 1'b0;
    end else begin
      unique case (rx_st)
        asp_pkg::RX_IDLE: if (rx_fall) begin
          rx_st <= asp_pkg::RX_START;
          rx_zero <= 1'b1;
          rx_perr <= 1'b0;
          rx_bit <= 3'h0;
        end
        asp_pkg::RX_START: begin
          // a glitch that is high again by mid-bit is no start
          if (samp & rxi) rx_st <= asp_pkg::RX_IDLE;
          else if (bend) rx_st <= asp_pkg::RX_DATA;
        end
        asp_pkg::RX_DATA: begin
          if (samp) begin
            rx_sh <= {rxi, rx_sh[7:1]};
            rx_zero <= rx_zero & ~rxi;
          end
          if (bend) begin
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              rx_st <= line_control[asp_pkg::LCR_PEN] ? asp_pkg::RX_PAR :
                       asp_pkg::RX_STOP;
            end
          end
        end
        asp_pkg::RX_PAR: begin
          if (samp) begin
            rx_perr <= rxi ^ asp_par(rx_data, line_control);
            rx_zero <= rx_zero & ~rxi;
          end
          if (bend) rx_st <= asp_pkg::RX_STOP;
        end
        asp_pkg::RX_STOP: if (samp) rx_st <= asp_pkg::RX_IDLE;
        default: rx_st <= asp_pkg::RX_IDLE;
      endcase
    end
  end

  // status flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer <= asp_pkg::RST_BYTE;
      dr <= 1'b0;
      oe <= 1'b0;
      pe <= 1'b0;
      fe <= 1'b0;
      bi <= 1'b0;
    end else begin
      if (rx_done) receive_buffer <= rx_data;
      dr <= (dr & ~rd_rbr) | rx_done;
      oe <= (oe & ~clr_oe) | (rx_done & dr);
      pe <= (pe & ~clr_pe) | (rx_done & rx_perr);
      fe <= (fe & ~clr_fe) | (rx_done & ~rxi);
      bi <= (bi & ~clr_bi) | (rx_done & rx_zero & ~rxi);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rda_p <= 1'b0;
      holding_empty_flag_p <= 1'b0;
      txe_p <= 1'b0;
      drx_p <= 1'b0;
      dtx_p <= 1'b0;
    end else begin
      rda_p <= (rda_p & ~clr_rda) | rx_done;
      holding_empty_flag_p <= (holding_empty_flag_p & ~clr_holding_empty_flag) | tx_load;
      txe_p <= (txe_p & ~clr_txe) | tx_done;
      drx_p <= (drx_p & ~clr_drx) | dma_rx_done;
      dtx_p <= (dtx_p & ~clr_dtx) | dma_tx_done;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_HOLD_FULL: assert property (wr_thr && !shifter_idle_flag |=> line_status[5] == 1'b0)
    else $error("holding empty still set after write");
  AST_LOAD: assert property (tx_load |=> tx_st == asp_pkg::TX_START ##0
    (!thr_full || $past(wr_thr)))
    else $error("empty shifter did not take holding data");
  AST_BREAK: assert property (line_control[asp_pkg::LCR_BRK] |=>
    !serial_out_line)
    else $error("break did not hold line low");
  AST_START_BIT: assert property (tx_st == asp_pkg::TX_START &&
    !line_control[asp_pkg::LCR_BRK] |=> serial_out_line == $past(line_inversion_control[0]))
    else $error("start bit level wrong");
  AST_NONE: assert property (act == 6'h00 |-> interrupt_identification == asp_pkg::IIR_NONE)
    else $error("id shows pending with nothing enabled");
  AST_RLS_TOP: assert property (rls && interrupt_enables[asp_pkg::IE_RLS] |->
    interrupt_identification == asp_pkg::IIR_RLS && irq)
    else $error("line status not top priority");
  AST_DR: assert property (rx_done |=> dr ##1 receive_buffer == $past(receive_buffer))
    else $error("data ready not set on store");
  AST_OVERRUN: assert property (rx_done && dr |=> oe)
    else $error("overrun missed");
  AST_LSR_CLR: assert property (rd_lsr && prdata[1] && !rx_done |=>
    !oe)
    else $error("status read left overrun set");
  AST_SHIFTER_IDLE_FLAG: assert property (tx_done |=> line_status[6])
    else $error("shifter idle flag not set at frame end");

  COV_RX: cover property (rx_done);
  COV_GAP: cover property (tx_st == asp_pkg::TX_GAP);
  COV_OE: cover property (rx_done && dr);
  COV_BRK: cover property (rx_done && rx_zero && !rxi);
endmodule // asp_channel

// file: verif/asp_partner.sv
`timescale 1ns/100ps
module asp_partner #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic inv,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  logic lvl = 1'b1;
  logic rxl;
  assign line_to_dut = lvl ^ inv;
  assign rxl = line_from_dut ^ inv;

  function automatic logic par_of(logic [7:0] d, logic [7:0] line_control);
    logic [7:0] m;
    m = d & (8'hff >> (3 - line_control[1:0]));
    return line_control[5] ? ~line_control[4] : (line_control[4] ? ^m : ~^m);
  endfunction

  // bad: 1 wrong parity, 2 stop low, 3 whole frame low (break)
  task automatic send(logic [7:0] d, logic [7:0] line_control, int bad);
    logic [11:0] f;
    int n;
    int s;
    n = 5 + int'(line_control[1:0]);
    s = n + 1 + int'(line_control[3]);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i+1] = d[i];
    if (line_control[3]) f[n+1] = par_of(d, line_control) ^ (bad == 1);
    if (bad == 2) f[s] = 1'b0;
    if (bad == 3) f = '0;
    // a 1.5 stop setting gets two stops: longer idle is still legal
    for (int i = 0; i <= s + int'(line_control[2]); i++) begin
      @(posedge clk);
      lvl <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    lvl <= 1'b1;
  endtask

  task automatic recv(logic [7:0] line_control, output logic [7:0] d,
                      output logic p, output logic stp);
    int n;
    n = 5 + int'(line_control[1:0]);
    d = '0;
    p = 1'b0;
    @(negedge rxl);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = rxl;
    end
    if (line_control[3]) begin
      repeat (BIT_CLKS) @(posedge clk);
      p = rxl;
    end
    repeat (BIT_CLKS) @(posedge clk);
    stp = rxl;
  endtask
endmodule // asp_partner

// file: verif/async_serial_port_channel_tb.sv
`timescale 1ns/100ps
module async_serial_port_channel_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic dma_rx_done = 1'b0;
  logic dma_tx_done = 1'b0;
  logic inv = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_out_line, irq, rx_line, err, ok;
  int fails = 0;
  int checks_done = 0;
  int cyc;
  logic [31:0] rdv;
  logic [7:0] pd;
  logic pp, ps;
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] d;
    logic [7:0] exp;
  } asp_row_t;
  asp_row_t rows [8] = '{'{8'h00, 8'hf5, 8'h15}, '{8'h01, 8'hf5, 8'h35},
    '{8'h06, 8'hf5, 8'h75}, '{8'h0f, 8'ha7, 8'ha7}, '{8'h1b, 8'ha5, 8'ha5},
    '{8'h2b, 8'h3c, 8'h3c}, '{8'h3b, 8'h3d, 8'h3d}, '{8'h04, 8'h0a, 8'h0a}};
  // start-to-start clocks of two back-to-back 0xff frames
  typedef struct packed {
    logic [7:0] line_control;
    logic [15:0] baud_divisor;
    logic [7:0] baud_fraction;
    logic [7:0] gap;
    logic [15:0] clk;
  } asp_span_t;
  asp_span_t spans [6] = '{'{8'h03, 16'h1, 8'h0, 8'h0, 16'd160},
    '{8'h07, 16'h1, 8'h0, 8'h0, 16'd176}, '{8'h04, 16'h1, 8'h0, 8'h0, 16'd120},
    '{8'h03, 16'h2, 8'h0, 8'h0, 16'd320}, '{8'h03, 16'h1, 8'h80, 8'h0, 16'd240},
    '{8'h03, 16'h1, 8'h0, 8'h02, 16'd192}};
  logic [7:0] ra [9] = '{asp_pkg::A_DATA, asp_pkg::A_IER, asp_pkg::A_IIR,
    asp_pkg::A_LCR, asp_pkg::A_DCR, asp_pkg::A_LSR, asp_pkg::A_BDR,
    asp_pkg::A_BFR, asp_pkg::A_INTERFRAME_DELAY};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00,
    8'h00, 8'h00};

  always #10 pclk = ~pclk;

  asp_channel i_asp_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_rx_done(dma_rx_done), .dma_tx_done(dma_tx_done),
    .serial_in_line(rx_line), .serial_out_line(serial_out_line), .irq(irq));
  asp_partner i_asp_partner (.clk(pclk), .inv(inv),
    .line_from_dut(serial_out_line), .line_to_dut(rx_line));

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait limit here: only the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask

  // status polling only clears error flags, harmless on the send side
  task automatic wait_idle();
    rdv = 32'h0;
    while (rdv !== 32'h60) begin
      apb(1'b0, asp_pkg::A_LSR, 32'h0);
    end
  endtask

  task automatic span(output int c);
    time t0;
    fork
      begin
        wr(asp_pkg::A_DATA, 32'hff);
        wr(asp_pkg::A_DATA, 32'hff);
      end
      begin
        @(negedge serial_out_line);
        t0 = $time;
        @(negedge serial_out_line);
        c = int'(($time - t0) / 20);
      end
    join
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    end_sim();
  end

  initial begin
    do_reset();
    wr(asp_pkg::A_BDR, 32'h1);
    foreach (rows[i]) begin
      wr(asp_pkg::A_LCR, {24'h0, rows[i].line_control});
      i_asp_partner.send(rows[i].d, rows[i].line_control, 0);
      repeat (8) @(posedge pclk);
      rchk(asp_pkg::A_LSR, 32'h61);
      rchk(asp_pkg::A_DATA, {24'h0, rows[i].exp});
      rchk(asp_pkg::A_LSR, 32'h60);
      fork
        i_asp_partner.recv(rows[i].line_control, pd, pp, ps);
        wr(asp_pkg::A_DATA, {24'h0, rows[i].d});
      join
      chk({24'h0, pd}, {24'h0, rows[i].exp});
      chk({31'h0, pp}, {31'h0, rows[i].line_control[3]
        & i_asp_partner.par_of(rows[i].d, rows[i].line_control)});
      chk({31'h0, ps}, 32'h1);
      wait_idle();
    end
    $display("frame table done");
    foreach (spans[i]) begin
      wr(asp_pkg::A_LCR, {24'h0, spans[i].line_control});
      wr(asp_pkg::A_BDR, {16'h0, spans[i].baud_divisor});
      wr(asp_pkg::A_BFR, {24'h0, spans[i].baud_fraction});
      wr(asp_pkg::A_INTERFRAME_DELAY, {24'h0, spans[i].gap});
      span(cyc);
      // a few clocks of load latency between frames are tolerated
      ok = cyc >= int'(spans[i].clk) && cyc <= int'(spans[i].clk) + 3;
      chk({31'h0, ok}, 32'h1);
      wait_idle();
    end
    $display("bit timing done");
    do_reset();
    chk({31'h0, serial_out_line}, 32'h1);
    foreach (ra[i]) rchk(ra[i], {24'h0, rv[i]});
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdv, 32'h0);
    wr(asp_pkg::A_LSR, 32'h0);
    rchk(asp_pkg::A_LSR, 32'h60);
    $display("reset and map done");
    wr(asp_pkg::A_BDR, 32'h1);
    wr(asp_pkg::A_LCR, 32'h03);
    wr(asp_pkg::A_IER, 32'h0a);
    wr(asp_pkg::A_DATA, 32'h3c);
    rchk(asp_pkg::A_DATA, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rchk(asp_pkg::A_IIR, 32'h02);
    rchk(asp_pkg::A_IIR, 32'h01);
    wait_idle();
    repeat (4) @(posedge pclk);
    rchk(asp_pkg::A_IIR, 32'h10);
    rchk(asp_pkg::A_IIR, 32'h01);
    wr(asp_pkg::A_IER, 32'h0);
    @(posedge pclk);
    dma_rx_done <= 1'b1;
    dma_tx_done <= 1'b1;
    @(posedge pclk);
    dma_rx_done <= 1'b0;
    dma_tx_done <= 1'b0;
    rchk(asp_pkg::A_IIR, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wr(asp_pkg::A_IER, 32'h30);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rchk(asp_pkg::A_IIR, 32'h0c);
    rchk(asp_pkg::A_IIR, 32'h0a);
    rchk(asp_pkg::A_IIR, 32'h01);
    $display("interrupt sources done");
    wr(asp_pkg::A_IER, 32'h07);
    i_asp_partner.send(8'h11, 8'h03, 0);
    i_asp_partner.send(8'h22, 8'h03, 0);
    repeat (8) @(posedge pclk);
    rchk(asp_pkg::A_IIR, 32'h06);
    rchk(asp_pkg::A_LSR, 32'h63);
    rchk(asp_pkg::A_IIR, 32'h04);
    rchk(asp_pkg::A_DATA, 32'h22);
    rchk(asp_pkg::A_IIR, 32'h01);
    wr(asp_pkg::A_LCR, 32'h1b);
    for (int k = 1; k < 4; k++) begin
      i_asp_partner.send(8'h5a, 8'h1b, k);
      repeat (8) @(posedge pclk);
      rchk(asp_pkg::A_IIR, 32'h06);
      apb(1'b0, asp_pkg::A_LSR, 32'h0);
      chk(rdv & (k == 3 ? 32'h14 : 32'h1c),
          k == 1 ? 32'h04 : (k == 2 ? 32'h08 : 32'h10));
      apb(1'b0, asp_pkg::A_DATA, 32'h0);
      rchk(asp_pkg::A_LSR, 32'h60);
    end
    $display("receive errors done");
    wr(asp_pkg::A_LCR, 32'h43);
    repeat (4) @(posedge pclk);
    chk({31'h0, serial_out_line}, 32'h0);
    wr(asp_pkg::A_LCR, 32'h03);
    repeat (4) @(posedge pclk);
    chk({31'h0, serial_out_line}, 32'h1);
    wr(asp_pkg::A_DATA, 32'h81);
    wr(asp_pkg::A_DATA, 32'h82);
    rchk(asp_pkg::A_LSR, 32'h00);
    wait_idle();
    wr(asp_pkg::A_DCR, 32'h0c);
    inv <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, serial_out_line}, 32'h0);
    i_asp_partner.send(8'hc3, 8'h03, 0);
    repeat (8) @(posedge pclk);
    rchk(asp_pkg::A_DATA, 32'hc3);
    fork
      i_asp_partner.recv(8'h03, pd, pp, ps);
      wr(asp_pkg::A_DATA, 32'h96);
    join
    chk({24'h0, pd}, 32'h96);
    $display("break and inversion done");
    end_sim();
  end
endmodule // async_serial_port_channel_tb
